// >>> gpio_commit_pkg.sv
// Constants, offsets and bus carrier for the commit-protection block
package gpio_commit_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PIN_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_AFSEL = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_LOCK = 12'h520;
  localparam logic [ADDR_W-1:0] OFS_COMMIT = 12'h524;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h600;
  localparam logic [ADDR_W-1:0] OFS_IDENT4 = 12'hFD0;
  localparam logic [ADDR_W-1:0] OFS_IDENT5 = 12'hFD4;
  localparam logic [ADDR_W-1:0] OFS_IDENT6 = 12'hFD8;

  // Lock key and lock read-back values
  localparam logic [DATA_W-1:0] LOCK_KEY = 32'h1ACCE551;
  localparam logic [DATA_W-1:0] LOCK_RD_LOCKED = 32'h0000_0001;
  localparam logic [DATA_W-1:0] LOCK_RD_OPEN = 32'h0000_0000;

  // Protected pin sets per port kind
  localparam logic [PIN_W-1:0] MASK_ORDINARY = 8'h00;
  localparam logic [PIN_W-1:0] MASK_PORT_B = 8'h80;
  localparam logic [PIN_W-1:0] MASK_PORT_C = 8'h0F;

  // Identification byte positions in the combined value
  localparam int IDENT4_LSB = 0;
  localparam int IDENT5_LSB = 8;
  localparam int IDENT6_LSB = 16;
  localparam int IDENT_BYTE_W = 8;

  // Status register fields
  localparam int STAT_LOCKED_BIT = 0;
  localparam int STAT_REFUSED_BIT = 1;

  // Reset value of the lock
  localparam logic LOCK_RST = 1'b1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// >>> commit_cell.sv
// One pin's commit bit and alternate-function select bit
`timescale 1ns/1ps
`default_nettype none
module commit_cell #(
  parameter logic WRITABLE = 1'b0,
  parameter logic AFSEL_RST = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Write requests
  input wire logic commit_we,
  input wire logic afsel_we,
  input wire logic wbit,
  // State
  output logic commit_q,
  output logic afsel_q
);

  logic commit_d;
  logic afsel_d;

  // Non-debug pins hold one whatever is written
  assign commit_d = WRITABLE ? (commit_we ? wbit : commit_q) : 1'b1;
  // Committed bits take the new value, others keep the old
  assign afsel_d = (afsel_we && commit_q) ? wbit : afsel_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      commit_q <= ~WRITABLE;
      afsel_q <= AFSEL_RST;
    end else begin
      commit_q <= commit_d;
      afsel_q <= afsel_d;
    end
  end

endmodule
`default_nettype wire

// >>> gpio_commit_protection.sv
// Commit protection for one port's alternate-function select bits
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module gpio_commit_protection #(
  parameter logic [7:0] PROTECTED_PINS = gpio_commit_pkg::MASK_ORDINARY,
  // Identification value is arbitrary
  parameter logic [31:0] IDENT_VALUE = 32'h00C3_5A96
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire gpio_commit_pkg::reg_req_t bus_req,
  output logic [gpio_commit_pkg::DATA_W-1:0] rdata_q,
  // Port state
  output logic [gpio_commit_pkg::PIN_W-1:0] alt_function_select,
  output logic [gpio_commit_pkg::PIN_W-1:0] commit_bits,
  output logic lock_closed
);

  localparam int DW = gpio_commit_pkg::DATA_W;
  localparam int PW = gpio_commit_pkg::PIN_W;
  localparam int IW = gpio_commit_pkg::IDENT_BYTE_W;

  // Only the documented port kinds are served
  if (PROTECTED_PINS != gpio_commit_pkg::MASK_ORDINARY &&
      PROTECTED_PINS != gpio_commit_pkg::MASK_PORT_B &&
      PROTECTED_PINS != gpio_commit_pkg::MASK_PORT_C) begin : g_bad_pins
    $error("PROTECTED_PINS must name an ordinary, B or C port");
  end

  logic locked_q;
  logic locked_d;
  logic refused_q;
  logic refused_d;
  logic [DW-1:0] rdata_d;
  logic [DW-1:0] rd_value;
  logic [PW-1:0] commit_w;
  logic [PW-1:0] afsel_w;

  // Address decode
  wire hit_afsel = bus_req.addr == gpio_commit_pkg::OFS_AFSEL;
  wire hit_lock = bus_req.addr == gpio_commit_pkg::OFS_LOCK;
  wire hit_commit = bus_req.addr == gpio_commit_pkg::OFS_COMMIT;
  wire hit_status = bus_req.addr == gpio_commit_pkg::OFS_STATUS;
  wire hit_id4 = bus_req.addr == gpio_commit_pkg::OFS_IDENT4;
  wire hit_id5 = bus_req.addr == gpio_commit_pkg::OFS_IDENT5;
  wire hit_id6 = bus_req.addr == gpio_commit_pkg::OFS_IDENT6;

  // Write strobes
  wire wr_afsel = bus_req.wr && hit_afsel;
  wire wr_lock = bus_req.wr && hit_lock;
  wire wr_commit = bus_req.wr && hit_commit;
  wire wr_status = bus_req.wr && hit_status;

  // Mask write passes only while unlocked, else dropped and flagged as refused
  wire commit_take = wr_commit && !locked_q;
  wire commit_refused = wr_commit && locked_q;

  // Key opens the lock, any other value closes it
  wire key_match = bus_req.wdata == gpio_commit_pkg::LOCK_KEY;
  assign locked_d = wr_lock ? !key_match : locked_q;

  // Sticky refused-write flag; a new refusal beats the clear
  wire refused_clr = wr_status &&
    bus_req.wdata[gpio_commit_pkg::STAT_REFUSED_BIT];
  assign refused_d = commit_refused || (refused_q && !refused_clr);

  // One cell per pin; only debug pins get a writable mask bit
  for (genvar i = 0; i < PW; i++) begin : g_pin
    commit_cell #(
      .WRITABLE(PROTECTED_PINS[i]),
      .AFSEL_RST(PROTECTED_PINS[i])
    ) u_cell (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .commit_we(commit_take),
      .afsel_we(wr_afsel),
      .wbit(bus_req.wdata[i]),
      .commit_q(commit_w[i]),
      .afsel_q(afsel_w[i])
    );
  end

  // Read-back values, upper bits zero
  wire [DW-1:0] rd_afsel = {{(DW-PW){1'b0}}, afsel_w};
  wire [DW-1:0] rd_commit = {{(DW-PW){1'b0}}, commit_w};
  wire [DW-1:0] rd_lock = locked_q ? gpio_commit_pkg::LOCK_RD_LOCKED :
    gpio_commit_pkg::LOCK_RD_OPEN;
  wire [DW-1:0] rd_status = {{(DW-2){1'b0}}, refused_q, locked_q};
  // Each identification byte alone in its register
  wire [DW-1:0] rd_id4 =
    {{(DW-IW){1'b0}}, IDENT_VALUE[gpio_commit_pkg::IDENT4_LSB +: IW]};
  wire [DW-1:0] rd_id5 =
    {{(DW-IW){1'b0}}, IDENT_VALUE[gpio_commit_pkg::IDENT5_LSB +: IW]};
  wire [DW-1:0] rd_id6 =
    {{(DW-IW){1'b0}}, IDENT_VALUE[gpio_commit_pkg::IDENT6_LSB +: IW]};

  // Read select; unmapped addresses read zero
  assign rd_value = hit_afsel ? rd_afsel :
    hit_commit ? rd_commit :
    hit_lock ? rd_lock :
    hit_status ? rd_status :
    hit_id4 ? rd_id4 :
    hit_id5 ? rd_id5 :
    hit_id6 ? rd_id6 : '0;
  assign rdata_d = bus_req.rd ? rd_value : '0;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      locked_q <= gpio_commit_pkg::LOCK_RST;
      refused_q <= 1'b0;
      rdata_q <= '0;
      alt_function_select <= PROTECTED_PINS;
      commit_bits <= ~PROTECTED_PINS;
      lock_closed <= gpio_commit_pkg::LOCK_RST;
    end else begin
      locked_q <= locked_d;
      refused_q <= refused_d;
      rdata_q <= rdata_d;
      alt_function_select <= afsel_w;
      commit_bits <= commit_w;
      lock_closed <= locked_d;
    end
  end

endmodule
`default_nettype wire

// >>> gpio_commit_protection_props.sv
// Port checker for the commit protection block
`timescale 1ns/1ps
`default_nettype none
module gpio_commit_props #(
  parameter logic [7:0] PROTECTED_PINS = 8'h00
) (
  // Watched ports
  input wire logic clk_sys,
  input wire logic rstn,
  input wire gpio_commit_pkg::reg_req_t bus_req,
  input wire logic [31:0] rdata_q,
  input wire logic [7:0] alt_function_select,
  input wire logic [7:0] commit_bits,
  input wire logic lock_closed
);
  wire w = bus_req.wr;
  wire lk = bus_req.addr == gpio_commit_pkg::OFS_LOCK;
  wire cm = bus_req.addr == gpio_commit_pkg::OFS_COMMIT;
  wire sw = w && bus_req.addr == gpio_commit_pkg::OFS_AFSEL;
  wire key = bus_req.wdata == gpio_commit_pkg::LOCK_KEY;
  wire [7:0] wd = bus_req.wdata[7:0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  rd_upper_a: assert property (
    bus_req.rd |=> rdata_q[31:8] == 24'h0) else $error("upper bits set");
  lock_open_a: assert property (
    w && lk && key |-> ##[1:2] !lock_closed) else $error("no unlock");
  lock_shut_a: assert property (
    w && lk && !key |-> ##[1:2] lock_closed) else $error("no relock");
  lock_read_a: assert property (
    bus_req.rd && lk |=> rdata_q == {31'h0, $past(lock_closed)})
    else $error("bad lock status");
  fixed_ones_a: assert property (
    (commit_bits | PROTECTED_PINS) == 8'hFF) else $error("mask bit low");
  locked_mask_a: assert property (
    w && cm && lock_closed |=> ##1 $stable(commit_bits))
    else $error("locked mask moved");
  mask_write_a: assert property (
    w && cm && !lock_closed |-> ##2
    commit_bits == ($past(wd, 2) | ~PROTECTED_PINS)) else $error("bad mask");
  commit_sel_a: assert property (
    sw |=> ##1 alt_function_select == (($past(wd, 2) & $past(commit_bits))
    | ($past(alt_function_select) & ~$past(commit_bits))))
    else $error("bad select");
  cover property (w && lk && key);
  cover property (w && cm && !lock_closed);
  cover property (sw);
  cover property (w && cm && lock_closed);
endmodule
bind gpio_commit_protection gpio_commit_props #(
  .PROTECTED_PINS(PROTECTED_PINS)) chk (.clk_sys(clk_sys), .rstn(rstn),
  .bus_req(bus_req), .rdata_q(rdata_q), .commit_bits(commit_bits),
  .alt_function_select(alt_function_select), .lock_closed(lock_closed));
`default_nettype wire

// >>> gpio_commit_protection_tb.sv
// Self-checking bench for the commit protection block
`timescale 1ns/1ps
`default_nettype none
module gpio_commit_protection_tb;
  // Identification value is arbitrary
  localparam logic [31:0] IDV = 32'h0042_B17E;
  localparam logic [11:0] SEL = 12'h100;
  localparam logic [11:0] LCK = 12'h520;
  localparam logic [11:0] CMT = 12'h524;
  localparam logic [11:0] STS = gpio_commit_pkg::OFS_STATUS;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  gpio_commit_pkg::reg_req_t req = '0;
  logic [31:0] rdata_q;
  logic [7:0] afs;
  logic [7:0] cmb;
  logic lkc;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  always #50 clk_sys = ~clk_sys;
  gpio_commit_protection #(.PROTECTED_PINS(gpio_commit_pkg::MASK_PORT_C),
    .IDENT_VALUE(IDV)) uut (.clk_sys(clk_sys), .rstn(rstn), .bus_req(req),
    .rdata_q(rdata_q), .alt_function_select(afs), .commit_bits(cmb),
    .lock_closed(lkc));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'h1;
    @(posedge clk_sys);
    req.wr <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd <= 1'h1;
    @(posedge clk_sys);
    req.rd <= 1'h0;
    #1 chk(rdata_q, e);
  endtask
  task automatic t_locked;
    #1 chk({24'h0, cmb}, 32'h0000_00F0);
    chk({24'h0, afs}, 32'h0000_000F);
    chk({31'h0, lkc}, 32'h0000_0001);
    rd(CMT, 32'h0000_00F0);
    rd(LCK, 32'h0000_0001);
    wr(CMT, 32'hFFFF_FFFF);
    rd(CMT, 32'h0000_00F0);
    wr(SEL, 32'h0000_00A0);
    rd(SEL, 32'h0000_00AF);
    chk({24'h0, afs}, 32'h0000_00AF);
    $display("locked test done");
  endtask
  task automatic t_unlock;
    wr(LCK, 32'h1ACC_E551);
    rd(LCK, 32'h0000_0000);
    chk({31'h0, lkc}, 32'h0000_0000);
    wr(CMT, 32'hFFFF_FF05);
    rd(CMT, 32'h0000_00F5);
    chk({24'h0, cmb}, 32'h0000_00F5);
    wr(SEL, 32'h0000_0000);
    rd(SEL, 32'h0000_000A);
    chk({24'h0, afs}, 32'h0000_000A);
    wr(LCK, 32'h0000_0001);
    rd(LCK, 32'h0000_0001);
    chk({31'h0, lkc}, 32'h0000_0001);
    wr(CMT, 32'h0000_000F);
    rd(CMT, 32'h0000_00F5);
    $display("unlock test done");
  endtask
  task automatic t_status;
    rd(STS, 32'h0000_0003);
    wr(STS, 32'h0000_0002);
    rd(STS, 32'h0000_0001);
    wr(CMT, 32'h0000_0000);
    rd(STS, 32'h0000_0003);
    $display("status test done");
  endtask
  task automatic t_reset;
    wr(LCK, 32'h1ACC_E551);
    @(posedge clk_sys);
    rstn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    #1 chk({24'h0, cmb}, 32'h0000_00F0);
    chk({24'h0, afs}, 32'h0000_000F);
    chk({31'h0, lkc}, 32'h0000_0001);
    rd(CMT, 32'h0000_00F0);
    rd(LCK, 32'h0000_0001);
    rd(STS, 32'h0000_0001);
    $display("reset test done");
  endtask
  task automatic t_ident;
    rd(12'hFD0, {24'h0, IDV[7:0]});
    rd(12'hFD4, {24'h0, IDV[15:8]});
    rd(12'hFD8, {24'h0, IDV[23:16]});
    wr(12'hFD0, 32'h0000_00FF);
    rd(12'hFD0, {24'h0, IDV[7:0]});
    rd(12'h004, 32'h0000_0000);
    $display("ident test done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      mismatches++;
      results;
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'h1;
    t_locked;
    t_unlock;
    t_status;
    t_reset;
    t_ident;
    results;
  end
endmodule
`default_nettype wire
